// *** logic/sta_addr_mem.sv ***
/*
 Station address storage for all ports, with a registered read port.
 Assumes writes and reads come from the APB slave on the same clock.
*/
`timescale 1ns/1ps
module sta_addr_mem #(
	parameter int PORTS = 6,
	parameter int PW = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic wr_high,
	input wire logic [PW-1:0] wr_port,
	input wire logic [31:0] wr_data,
	input wire logic [PW-1:0] rd_port,
	input wire logic rd_high,
	output logic [31:0] rd_data,
	output logic [PORTS*48-1:0] addr_flat
);
	import sta_addr_pkg::*;

	logic [31:0] low_r [PORTS];
	logic [31:0] low_nxt [PORTS];
	logic [15:0] high_r [PORTS];
	logic [15:0] high_nxt [PORTS];
	logic [31:0] rd_data_nxt;

	genvar g;
	generate
		for (g = 0; g < PORTS; g++) begin : gen_port
			always_comb begin
				low_nxt[g] = low_r[g];
				high_nxt[g] = high_r[g];
				if (wr_en && wr_port == PW'(g)) begin
					if (wr_high) begin
						high_nxt[g] = wr_data[HIGH_FIELD_W-1:0];
					end else begin
						low_nxt[g] = wr_data;
					end
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					low_r[g] <= STATION_ADDR_LOW_RST;
					high_r[g] <= STATION_ADDR_HIGH_RST;
				end else begin
					low_r[g] <= low_nxt[g];
					high_r[g] <= high_nxt[g];
				end
			end
			assign addr_flat[g*48 +: 48] = {high_r[g], low_r[g]};
		end
	endgenerate

	always_comb begin
		rd_data_nxt = 32'h0000_0000;
		for (int i = 0; i < PORTS; i++) begin
			if (rd_port == PW'(i)) begin
				// Upper half of the high word always reads zero
				rd_data_nxt = rd_high ? {16'h0000, high_r[i]} : low_r[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= rd_data_nxt;
		end
	end
endmodule

// *** logic/sta_addr_regs.sv ***
/*
 APB register bank for per-port station addresses, with pause frame
 source address output and receive destination address comparison.
 Assumes an APB master on pclk; MAC datapaths on the same clock.
*/
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module sta_addr_regs #(
	parameter int PORTS = sta_addr_pkg::NUM_PORTS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [sta_addr_pkg::PORT_BITS-1:0] tx_pause_port,
	output logic [sta_addr_pkg::MAC_ADDR_W-1:0] tx_pause_src_addr,
	input wire logic rx_pause_valid,
	input wire logic rx_pause_unicast,
	input wire logic [sta_addr_pkg::PORT_BITS-1:0] rx_pause_port,
	input wire logic [sta_addr_pkg::MAC_ADDR_W-1:0] rx_pause_dst_addr,
	output logic rx_pause_match
);
	import sta_addr_pkg::*;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Word index = paddr[11:2]; bit 0 picks the register, upper bits the port
	logic [9:0] word_idx;
	logic [PORT_BITS-1:0] acc_port;
	logic acc_high;
	logic mapped;
	logic setup;
	logic access_done;
	logic rd_phase_r;
	logic rd_phase_nxt;
	logic err_r;
	logic err_nxt;
	logic [31:0] mem_rdata;
	logic [PORTS*48-1:0] addr_flat;
	logic tx_port_ok;
	logic rx_port_ok;
	logic [47:0] tx_src_nxt;
	logic [47:0] tx_src_r;
	logic match_nxt;
	logic match_r;

	assign word_idx = paddr[11:2];
	assign acc_port = word_idx[PORT_BITS:1];
	assign acc_high = word_idx[0] == STATION_ADDR_HIGH_IDX[0];
	assign mapped = (word_idx[9:PORT_BITS+1] == '0) && (acc_port <= PORT_BASE_MAX)
		&& (paddr[1:0] == 2'h0);
	assign setup = psel && !penable;
	assign access_done = psel && penable && pready;

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// Reads take one wait state so data comes from the memory's output register
	always_comb begin
		rd_phase_nxt = 1'b0;
		err_nxt = err_r;
		if (setup) begin
			rd_phase_nxt = !pwrite;
			err_nxt = !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_phase_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			rd_phase_r <= rd_phase_nxt;
			err_r <= err_nxt;
		end
	end

	assign pready = psel && penable && !rd_phase_r;
	assign pslverr = access_done && err_r;
	assign prdata = (access_done && !pwrite && !err_r) ? mem_rdata : UNMAPPED_RDATA;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Only full-word writes land; partial strobes are ignored to keep the pair coherent
	sta_addr_mem #(
		.PORTS(PORTS),
		.PW(PORT_BITS)
	) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(access_done && pwrite && !err_r && pstrb == 4'hf),
		.wr_high(acc_high),
		.wr_port(acc_port),
		.wr_data(pwdata),
		.rd_port(acc_port),
		.rd_high(acc_high),
		.rd_data(mem_rdata),
		.addr_flat(addr_flat)
	);

	// ----------------------------------------
	// Pause frame use
	// ----------------------------------------
	assign tx_port_ok = int'(tx_pause_port) < PORTS;
	assign rx_port_ok = int'(rx_pause_port) < PORTS;

	always_comb begin
		tx_src_nxt = 48'h0000_0000_0000;
		match_nxt = 1'b0;
		for (int i = 0; i < PORTS; i++) begin
			if (tx_port_ok && tx_pause_port == PORT_BITS'(i)) begin
				tx_src_nxt = addr_flat[i*48 +: 48];
			end
			if (rx_port_ok && rx_pause_port == PORT_BITS'(i)) begin
				match_nxt = rx_pause_valid && rx_pause_unicast
					&& (rx_pause_dst_addr == addr_flat[i*48 +: 48]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_src_r <= 48'h0000_0000_0000;
			match_r <= 1'b0;
		end else begin
			tx_src_r <= tx_src_nxt;
			match_r <= match_nxt;
		end
	end

	assign tx_pause_src_addr = tx_src_r;
	assign rx_pause_match = match_r;
endmodule

// *** pkg/sta_addr_pkg.sv ***
/*
 Constants for the per-port station address register bank.
 Assumes an APB master on pclk with 32-bit data and word-aligned registers.
*/
package sta_addr_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int NUM_PORTS = 6;
	localparam int PORT_BITS = 3;
	localparam logic [PORT_BITS-1:0] PORT_BASE_MAX = 3'h5;
	localparam logic [0:0] STATION_ADDR_LOW_IDX = 1'h0;
	localparam logic [0:0] STATION_ADDR_HIGH_IDX = 1'h1;
	localparam logic [31:0] STATION_ADDR_LOW_RST = 32'h0000_0000;
	localparam logic [15:0] STATION_ADDR_HIGH_RST = 16'h0000;
	localparam int HIGH_FIELD_W = 16;
	localparam int MAC_ADDR_W = 48;
	localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
endpackage

// *** verification/sta_addr_regs_bench.sv ***
/*
 Self-checking bench for sta_addr_regs.
 Assumes the checker binds itself.
*/
`timescale 1ns/1ps
module sta_addr_regs_bench;
	import sta_addr_pkg::*;
	// ------------------------------
	// Stimulus and checking
	// ------------------------------
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic rx_pause_valid = 1'h0, rx_pause_unicast = 1'h0, pready, pslverr, rx_pause_match, pend = 1'h0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] tx_pause_port = '0, rx_pause_port = '0;
	logic [47:0] tx_pause_src_addr, rx_pause_dst_addr = '0, e, f;
	logic [31:0] m [12] = '{default: '0};
	logic [32:0] q [$];
	logic [48:0] pq [$], hit;
	int seed = 97351, n_fail = 0, checks = 0, cyc = 0;
	sta_addr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .tx_pause_port, .tx_pause_src_addr, .rx_pause_valid, .rx_pause_unicast, .rx_pause_port,
		.rx_pause_dst_addr, .rx_pause_match);
	initial forever #25 pclk = ~pclk;
	task chk_bus(input logic [32:0] g, input logic [32:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task chk_src(input logic [47:0] g, input logic [47:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task chk_match(input logic g, input logic x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task tally_and_finish;
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Model updated at request time; only full-strobe mapped writes land
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ok;
		ok = a[1:0] == 2'h0 && a[11:3] < 9'h6;
		if (w && ok && s == 4'hf) m[a[5:2]] = a[2] ? {16'h0, d[15:0]} : d;
		q.push_back({!ok, (w || !ok) ? 32'h0 : m[a[5:2]]});
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish;
		end
		if (psel && penable && pready) chk_bus({pslverr, prdata}, q.pop_front());
		if (pend) begin
			hit = pq.pop_front();
			chk_src(tx_pause_src_addr, hit[48:1]);
			chk_match(rx_pause_match, hit[0]);
		end
		pend = rx_pause_valid;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 12; i++) apb(1'h0, 12'(4 * i), '0, 4'hf);
		for (int i = 0; i < 12; i++) apb(1'h1, 12'(4 * i), $random(seed), 4'hf);
		for (int i = 0; i < 12; i++) apb(1'h0, 12'(4 * i), '0, 4'hf);
		apb(1'h1, 12'h4, 32'hffff_ffff, 4'h3);
		apb(1'h1, 12'h30, 32'h1, 4'hf);
		apb(1'h1, 12'h2, 32'h1, 4'hf);
		apb(1'h0, 12'h30, '0, 4'hf);
		apb(1'h0, 12'h4, '0, 4'hf);
		for (int p = 0; p < 7; p++) for (int k = 0; k < 3; k++) begin
			e = p < 6 ? {m[2 * p + 1][15:0], m[2 * p]} : 48'h0;
			f = 48'h1 << ($unsigned($random(seed)) % 48);
			pq.push_back({e, p < 6 && k == 0});
			@(posedge pclk);
			tx_pause_port <= 3'(p);
			rx_pause_port <= 3'(p);
			rx_pause_valid <= 1'h1;
			rx_pause_unicast <= k != 2;
			rx_pause_dst_addr <= k == 1 ? e ^ f : e;
			@(posedge pclk);
			rx_pause_valid <= 1'h0;
		end
		repeat (3) @(posedge pclk);
		// Mid-run reset must bring every station address back to zero
		presetn <= 1'h0;
		m = '{default: '0};
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 12; i++) apb(1'h0, 12'(4 * i), '0, 4'hf);
		repeat (3) @(posedge pclk);
		tally_and_finish;
	end
endmodule

// *** verification/sta_addr_regs_sva.sv ***
/*
 Port checker for sta_addr_regs.
 Assumes bind to the top module, one clock.
*/
`timescale 1ns/1ps
module sta_addr_regs_sva #(
	parameter int PORTS = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_pause_valid,
	input wire logic rx_pause_unicast,
	input wire logic [2:0] rx_pause_port,
	input wire logic rx_pause_match
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire done = psel && penable && pready;
	property p_wr; psel && penable && pwrite |-> pready; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_rd; psel && !penable && !pwrite |=> !pready ##1 pready; endproperty
	a_rd: assert property (p_rd) else $error("read timing");
	property p_z; !done || pwrite |-> prdata == 32'h0; endproperty
	a_z: assert property (p_z) else $error("stray read data");
	property p_al; done && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_al: assert property (p_al) else $error("unaligned taken");
	property p_pt; done && paddr[11:3] >= PORTS |-> pslverr; endproperty
	a_pt: assert property (p_pt) else $error("bad port taken");
	property p_ok; done && paddr[1:0] == 2'h0 && paddr[11:3] < PORTS |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("good port refused");
	property p_hi; done && !pwrite && paddr[2] |-> prdata[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("high bits set");
	property p_er; pslverr |-> done; endproperty
	a_er: assert property (p_er) else $error("stray error");
	property p_m; rx_pause_match |-> $past(rx_pause_valid && rx_pause_unicast && rx_pause_port < PORTS); endproperty
	a_m: assert property (p_m) else $error("match without cause");
	c_rd: cover property (done && !pwrite && !pslverr);
	c_er: cover property (done && pslverr);
	c_m: cover property (rx_pause_match);
endmodule
bind sta_addr_regs sta_addr_regs_sva #(.PORTS(PORTS)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .rx_pause_valid, .rx_pause_unicast, .rx_pause_port, .rx_pause_match);
